// ---- verilog/hbf_regs.vh ----
`ifndef HBF_REGS_VH
`define HBF_REGS_VH
// serial output status bit positions
`define HBF_SO_THERMAL_WARN 4'h0
`define HBF_SO_LOW_LOAD 4'hD
`define HBF_SO_SUPPLY_FAULT 4'hE
`define HBF_SO_LATCHED 4'hF
// serial input control bit positions
`define HBF_SI_OV_TRIP 4'h0
`define HBF_SI_LOW_LOAD_TRIP 4'hD
// per-bridge fault codes
`define HBF_CODE_NONE 2'h0
`define HBF_CODE_OVERCURRENT 2'h1
`define HBF_CODE_LOW_LOAD 2'h2
`define HBF_CODE_THERMAL 2'h3
// reset values
`define HBF_RST_CFG 1'h0
`endif

// ---- verilog/hbf_sync.v ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// two-stage synchroniser for a bus of levels
// ----------------------------------------
module hbf_sync #(
	parameter W = 1
) (
	// clock
	input wire clk,
	input wire ce,
	// data
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;
	// first stage only feeds the second
	always @(posedge clk)
	begin
		if (ce)
		begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end
	assign q = sync_reg;
endmodule // hbf_sync
`default_nettype wire

// ---- verilog/hbf_bridge.v ----
`timescale 1ns/100ps
`default_nettype none
`include "hbf_regs.vh"
// ----------------------------------------
// fault state of one half-bridge
// ----------------------------------------
module hbf_bridge (
	// clock and reset
	input wire clk,
	input wire rst,
	input wire ce,
	// conditions, synchronised
	input wire tsd,
	input wire oc,
	input wire low_load_flag,
	input wire uld_trip,
	// clear request and new configuration
	input wire clr,
	input wire tsd_clear_ok,
	input wire load,
	input wire cfg_en,
	input wire cfg_side,
	// state out
	output wire en_out,
	output wire side_out,
	output wire latched_off,
	output wire [1:0] code,
	output wire tsd_seen,
	output wire uld_seen
);
	reg en_reg;
	reg side_reg;
	reg off_reg;
	reg oc_reg;
	reg uld_reg;
	reg tsd_reg;
	wire trip;
	wire clr_tsd;
	wire off_clr;
	// a new latched cause this cycle
	assign trip = tsd | oc | (low_load_flag & uld_trip);
	assign clr_tsd = clr & tsd_clear_ok;
	// latch-off released, overheat needs a cool die
	assign off_clr = clr & (~tsd_reg | clr_tsd);
	// flags: set wins over clear, tsd needs cool die to clear
	always @(posedge clk)
	begin
		if (rst)
		begin
			oc_reg <= 1'h0;
			uld_reg <= 1'h0;
			tsd_reg <= 1'h0;
			off_reg <= 1'h0;
		end
		else if (ce)
		begin
			oc_reg <= oc | (oc_reg & ~clr); // RQ15
			uld_reg <= low_load_flag | (uld_reg & ~clr); // RQ10
			tsd_reg <= tsd | (tsd_reg & ~clr_tsd); // RQ5 RQ6
			off_reg <= trip | (off_reg & ~off_clr); // RQ4 RQ16
		end
	end
	// configuration: latched fault forces zero, clear precedes reload
	always @(posedge clk)
	begin
		if (rst)
		begin
			en_reg <= `HBF_RST_CFG;
			side_reg <= `HBF_RST_CFG;
		end
		else if (ce)
		begin
			if (trip)
			begin
				en_reg <= 1'h0; // RQ7
				side_reg <= 1'h0; // RQ7
			end
			else if (load & (~off_reg | off_clr)) // RQ8
			begin
				en_reg <= cfg_en; // RQ17
				side_reg <= cfg_side;
			end
		end
	end
	assign en_out = en_reg & ~off_reg;
	assign side_out = side_reg;
	assign latched_off = off_reg;
	assign tsd_seen = tsd_reg;
	assign uld_seen = uld_reg; // RQ10
	// overcurrent code masks low-load code
	assign code = oc_reg ? `HBF_CODE_OVERCURRENT : // RQ15
		(uld_reg ? `HBF_CODE_LOW_LOAD : (tsd_reg ? `HBF_CODE_THERMAL : `HBF_CODE_NONE));
endmodule // hbf_bridge
`default_nettype wire

// ---- verilog/hbf_fault_manager.v ----
// Function
// RQ1 - Warm die sets status bit 0 while drivers stay active.
// RQ2 - The warning bit follows the sensor and clears itself when cool.
// RQ3 - Each bridge has its own shutdown sensor input.
// RQ4 - A bridge that overheats has both its drivers latched off, others untouched.
// RQ5 - Overheat sets a latched flag at status bit 15 that outlives the heat.
// RQ6 - That flag clears only on a clear frame while the die is below shutdown level; the code also clears it on an enable pin cycle.
// RQ7 - A latched fault zeroes the bridge enable and side select bits.
// RQ8 - The host clears flags and then resends configuration to restart a bridge.
// RQ9 - A locked-out bridge resumes its programmed state when the fault goes.
// RQ10 - A latched flag may stay set while outputs remain on.
// RQ11 - Latched faults clear on a clear frame, an enable pin cycle, or reset.
// RQ12 - Supply undervoltage locks all drivers off, keeps configuration, self-recovers.
// RQ13 - Supply overvoltage turns outputs off only with the trip enable bit set.
// RQ14 - Supply under or overvoltage sets self-clearing status bit 14.
// RQ15 - Overcurrent latches the bridge off, sets the global flag, code 01 wins.
// RQ16 - Low-load trips the bridge off only when its trip enable is set.
// RQ17 - Clear requests act at the end of a good frame, before new configuration.
`timescale 1ns/100ps
`default_nettype none
`include "hbf_regs.vh"
module hbf_fault_manager #(
	parameter NB = 6
) (
	// clock, reset, enable
	input wire CLK,
	input wire RST,
	input wire CE,
	// analog condition inputs, asynchronous
	input wire THERMAL_WARN_IN,
	input wire [NB-1:0] THERMAL_SHUTDOWN_IN,
	input wire [NB-1:0] OVERCURRENT_IN,
	input wire [NB-1:0] LOW_LOAD_IN,
	input wire SUPPLY_UNDERVOLT_IN,
	input wire SUPPLY_OVERVOLT_IN,
	input wire ENABLE_PIN,
	// decoded frame from the serial shifter, same clock
	input wire FRAME_VALID,
	input wire STATUS_CLEAR_REQUEST,
	input wire OVERVOLTAGE_TRIP_ENABLE,
	input wire LOW_LOAD_TRIP_ENABLE,
	input wire [NB-1:0] BRIDGE_OUTPUT_ENABLE,
	input wire [NB-1:0] BRIDGE_SIDE_SELECT,
	// driver controls
	output reg [NB-1:0] DRIVE_ENABLE,
	output reg [NB-1:0] DRIVE_SIDE,
	output reg [NB-1:0] LATCHED_OFF,
	// status word
	output reg [15:0] STATUS_WORD,
	output reg [2*NB-1:0] BRIDGE_FAULT_CODE
);
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	localparam SW = 3*NB + 4;
	wire [SW-1:0] s_q;
	wire tw_s;
	wire [NB-1:0] tsd_s;
	wire [NB-1:0] oc_s;
	wire [NB-1:0] uld_s;
	wire uv_s;
	wire ov_s;
	wire en_s;
	hbf_sync #(.W(SW)) u_sync (
		.clk(CLK),
		.ce(CE),
		.d({THERMAL_WARN_IN, THERMAL_SHUTDOWN_IN, OVERCURRENT_IN, LOW_LOAD_IN,
			SUPPLY_UNDERVOLT_IN, SUPPLY_OVERVOLT_IN, ENABLE_PIN}),
		.q(s_q)
	);
	assign {tw_s, tsd_s, oc_s, uld_s, uv_s, ov_s, en_s} = s_q;

	// ----------------------------------------
	// trip options and clear sources
	// ----------------------------------------
	reg ov_trip_reg;
	reg uld_trip_reg;
	reg en_prev_reg;
	wire frame_clr;
	wire pin_cycle;
	wire clr_any;
	wire load;
	// options take effect with each good frame
	always @(posedge CLK)
	begin
		if (RST)
		begin
			ov_trip_reg <= 1'h0;
			uld_trip_reg <= 1'h0;
			en_prev_reg <= 1'h1; // idle high pin, no false cycle after reset
		end
		else if (CE)
		begin
			en_prev_reg <= en_s;
			if (FRAME_VALID)
			begin
				ov_trip_reg <= OVERVOLTAGE_TRIP_ENABLE;
				uld_trip_reg <= LOW_LOAD_TRIP_ENABLE;
			end
		end
	end
	assign frame_clr = FRAME_VALID & STATUS_CLEAR_REQUEST; // RQ17
	assign pin_cycle = en_s & ~en_prev_reg; // RQ11
	assign clr_any = frame_clr | pin_cycle; // RQ11
	assign load = FRAME_VALID;

	// ----------------------------------------
	// per-bridge fault state
	// ----------------------------------------
	wire [NB-1:0] b_en;
	wire [NB-1:0] b_side;
	wire [NB-1:0] b_off;
	wire [NB-1:0] b_tsd;
	wire [NB-1:0] b_uld;
	wire [2*NB-1:0] b_code;
	genvar i;
	generate
		for (i = 0; i < NB; i = i + 1)
		begin : g_br
			hbf_bridge u_br (
				.clk(CLK),
				.rst(RST),
				.ce(CE),
				.tsd(tsd_s[i]), // RQ3
				.oc(oc_s[i]),
				.low_load_flag(uld_s[i]),
				.uld_trip(uld_trip_reg), // RQ16
				.clr(clr_any),
				.tsd_clear_ok(~tsd_s[i] | pin_cycle), // RQ6
				.load(load),
				.cfg_en(BRIDGE_OUTPUT_ENABLE[i]),
				.cfg_side(BRIDGE_SIDE_SELECT[i]),
				.en_out(b_en[i]),
				.side_out(b_side[i]),
				.latched_off(b_off[i]),
				.code(b_code[2*i+1:2*i]),
				.tsd_seen(b_tsd[i]),
				.uld_seen(b_uld[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// global flags held in the bridges
	// ----------------------------------------
	reg any_oc;
	reg any_uld;
	integer k;
	always @*
	begin
		any_oc = 1'h0;
		any_uld = |b_uld; // global low-load bit even when code shows overcurrent
		for (k = 0; k < NB; k = k + 1)
		begin
			any_oc = any_oc | (b_code[2*k+:2] == `HBF_CODE_OVERCURRENT);
		end
	end
	wire lockout;
	wire latched_any;
	assign lockout = uv_s | (ov_s & ov_trip_reg); // RQ12 RQ13
	assign latched_any = (|b_tsd) | any_oc; // RQ5 RQ15

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always @(posedge CLK)
	begin
		if (RST)
		begin
			DRIVE_ENABLE <= {NB{1'h0}};
			DRIVE_SIDE <= {NB{1'h0}};
			LATCHED_OFF <= {NB{1'h0}};
			STATUS_WORD <= 16'h0000;
			BRIDGE_FAULT_CODE <= {2*NB{1'h0}};
		end
		else if (CE)
		begin
			// lockout masks drives but keeps configuration
			DRIVE_ENABLE <= lockout ? {NB{1'h0}} : b_en; // RQ9 RQ12
			DRIVE_SIDE <= b_side;
			LATCHED_OFF <= b_off;
			BRIDGE_FAULT_CODE <= b_code;
			STATUS_WORD <= 16'h0000;
			STATUS_WORD[`HBF_SO_THERMAL_WARN] <= tw_s; // RQ1 RQ2
			STATUS_WORD[`HBF_SO_LOW_LOAD] <= any_uld; // RQ10
			STATUS_WORD[`HBF_SO_SUPPLY_FAULT] <= uv_s | ov_s; // RQ14
			STATUS_WORD[`HBF_SO_LATCHED] <= latched_any; // RQ5
		end
	end
endmodule // hbf_fault_manager
`default_nettype wire

// ---- sim/hbf_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// fault manager port checker
// --------------------------------
module hbf_checker #(parameter NB = 6) (
	// clock and reset
	input wire CLK,
	input wire RST,
	// conditions
	input wire THERMAL_WARN_IN,
	input wire [NB-1:0] THERMAL_SHUTDOWN_IN,
	input wire [NB-1:0] OVERCURRENT_IN,
	input wire SUPPLY_UNDERVOLT_IN,
	input wire ENABLE_PIN,
	input wire FRAME_VALID,
	// results
	input wire [NB-1:0] DRIVE_ENABLE,
	input wire [NB-1:0] DRIVE_SIDE,
	input wire [NB-1:0] LATCHED_OFF,
	input wire [15:0] STATUS_WORD,
	input wire [2*NB-1:0] BRIDGE_FAULT_CODE
);
default clocking @(posedge CLK); endclocking
default disable iff (RST);
// status bits trail the sensors by three edges
AST_WARN_SET: assert property (THERMAL_WARN_IN[*4] |-> STATUS_WORD[0])
	else $error("warning bit missing");
AST_UV_FLAG: assert property (SUPPLY_UNDERVOLT_IN[*4] |-> STATUS_WORD[14])
	else $error("supply bit missing");
// latched driver state trails the sensors by four edges, undervoltage lockout by three
AST_UV_LOCK: assert property (SUPPLY_UNDERVOLT_IN[*5] |-> !(|DRIVE_ENABLE))
	else $error("driver on in undervoltage");
AST_OC_LATCH: assert property (OVERCURRENT_IN[0][*5] |->
	LATCHED_OFF[0] && BRIDGE_FAULT_CODE[1:0] == 2'h1 && STATUS_WORD[15])
	else $error("overcurrent not latched");
AST_TSD_LATCH: assert property (THERMAL_SHUTDOWN_IN[0][*5] |->
	LATCHED_OFF[0] && !DRIVE_ENABLE[0] && STATUS_WORD[15])
	else $error("overheat not latched");
AST_ZERO_CFG: assert property (!(|(LATCHED_OFF & (DRIVE_ENABLE | DRIVE_SIDE))))
	else $error("latched bridge keeps config");
// the latched bit needs a frame or a pin cycle to go
AST_HOLD: assert property (((ENABLE_PIN && !FRAME_VALID)[*5] ##0 STATUS_WORD[15])
	|=> STATUS_WORD[15])
	else $error("latched bit lost");
AST_PIN_CLR: assert property (($rose(ENABLE_PIN) && !(|{OVERCURRENT_IN,
	THERMAL_SHUTDOWN_IN})) |-> ##[1:5] !STATUS_WORD[15])
	else $error("pin cycle did not clear");
// main scenarios
cover property (FRAME_VALID && |LATCHED_OFF);
cover property ($rose(ENABLE_PIN) && STATUS_WORD[15]);
cover property (STATUS_WORD[14] && |DRIVE_ENABLE);
endmodule // hbf_checker
`default_nettype wire

// ---- sim/hbf_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// --------------------------------
// host side frame source
// --------------------------------
module hbf_host (
	// clock
	input wire CLK,
	// decoded frame
	output var logic FRAME_VALID,
	output wire STATUS_CLEAR_REQUEST,
	output wire OVERVOLTAGE_TRIP_ENABLE,
	output wire LOW_LOAD_TRIP_ENABLE,
	output wire [5:0] BRIDGE_OUTPUT_ENABLE,
	output wire [5:0] BRIDGE_SIDE_SELECT
);
logic [14:0] f = 15'h0;
// frame fields in one word
assign {STATUS_CLEAR_REQUEST, OVERVOLTAGE_TRIP_ENABLE, LOW_LOAD_TRIP_ENABLE,
	BRIDGE_OUTPUT_ENABLE, BRIDGE_SIDE_SELECT} = f;
initial FRAME_VALID = 1'h0;
// one frame pulse, fields scrambled once it ends
task automatic send(input logic [14:0] v);
	@(negedge CLK);
	f = v;
	FRAME_VALID = 1'h1;
	@(negedge CLK);
	FRAME_VALID = 1'h0;
	f = ~v;
endtask
endmodule // hbf_host
`default_nettype wire

// ---- sim/hbf_fault_manager_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module hbf_fault_manager_tb;
logic CLK = 1'h0, RST = 1'h1, CE = 1'h1, THERMAL_WARN_IN = 1'h0, ENABLE_PIN = 1'h1;
logic SUPPLY_UNDERVOLT_IN = 1'h0, SUPPLY_OVERVOLT_IN = 1'h0;
logic [5:0] THERMAL_SHUTDOWN_IN = 6'h0, OVERCURRENT_IN = 6'h0, LOW_LOAD_IN = 6'h0, e, s, b;
wire FRAME_VALID, STATUS_CLEAR_REQUEST, OVERVOLTAGE_TRIP_ENABLE, LOW_LOAD_TRIP_ENABLE;
wire [5:0] BRIDGE_OUTPUT_ENABLE, BRIDGE_SIDE_SELECT, DRIVE_ENABLE, DRIVE_SIDE, LATCHED_OFF;
wire [15:0] STATUS_WORD;
wire [11:0] BRIDGE_FAULT_CODE;
int seed = 91, error_cnt = 0, n_compared = 0, cyc = 0;
hbf_fault_manager #(.NB(6)) dut (.*);
hbf_host host (.*);
// --------------------------------
// clock, timeout, helpers
// --------------------------------
initial forever #4 CLK = ~CLK;
always @(posedge CLK)
begin
	cyc++;
	if (cyc == 3000)
	begin
		error_cnt++;
		summarize();
	end
end
task automatic chk(input logic [39:0] seen, exp);
	n_compared++;
	if (seen !== exp)
	begin
		error_cnt++;
		$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic wt(input int n);
	repeat (n) @(negedge CLK);
endtask
task automatic summarize;
	$display("compared %0d mismatches %0d", n_compared, error_cnt);
	if (error_cnt == 0 && n_compared > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
// expected fault code word for the bridges in m
function automatic logic [11:0] code(input logic [5:0] m, input logic [1:0] c);
	code = 12'h0;
	for (int i = 0; i < 6; i++)
		if (m[i])
			code[2*i +: 2] = c;
endfunction
// random frame with bridge b on; opt is clear, overvoltage trip, low-load trip
task automatic cfg(input logic [2:0] opt);
	e = 6'($random(seed)) | b;
	s = 6'($random(seed));
	host.send({opt, e, s});
	wt(3);
endtask
// --------------------------------
// main sequence
// --------------------------------
initial
begin
	wt(10);
	RST = 1'h0;
	wt(4);
	chk({DRIVE_ENABLE, DRIVE_SIDE, LATCHED_OFF, STATUS_WORD}, 40'h0);
	for (int k = 0; k < 6; k++)
	begin
		b = 6'h1 << k;
		cfg(3'h4);
		chk({LATCHED_OFF, DRIVE_SIDE, DRIVE_ENABLE}, {6'h0, s, e});
		THERMAL_WARN_IN = 1'h1;
		SUPPLY_OVERVOLT_IN = 1'h1;
		wt(5);
		chk({DRIVE_ENABLE, STATUS_WORD}, {e, 16'h4001});
		cfg(3'h2);
		chk(DRIVE_ENABLE, 6'h0);
		THERMAL_WARN_IN = 1'h0;
		SUPPLY_OVERVOLT_IN = 1'h0;
		SUPPLY_UNDERVOLT_IN = 1'h1;
		wt(5);
		chk({DRIVE_ENABLE, STATUS_WORD}, 40'h4000);
		SUPPLY_UNDERVOLT_IN = 1'h0;
		wt(5);
		chk({DRIVE_ENABLE, STATUS_WORD}, {e, 16'h0});
		THERMAL_SHUTDOWN_IN = b;
		wt(5);
		chk({LATCHED_OFF, DRIVE_ENABLE, DRIVE_SIDE}, {b, e & ~b, s & ~b});
		chk({STATUS_WORD, BRIDGE_FAULT_CODE}, {16'h8000, code(b, 2'h3)});
		cfg(3'h4);
		chk({LATCHED_OFF, DRIVE_ENABLE}, {b, e & ~b});
		THERMAL_SHUTDOWN_IN = 6'h0;
		wt(5);
		chk(STATUS_WORD, 16'h8000);
		cfg(3'h4);
		chk({LATCHED_OFF, DRIVE_ENABLE}, {6'h0, e});
		OVERCURRENT_IN = b;
		LOW_LOAD_IN = b;
		wt(5);
		chk({LATCHED_OFF, STATUS_WORD, BRIDGE_FAULT_CODE}, {b, 16'hA000, code(b, 2'h1)});
		OVERCURRENT_IN = 6'h0;
		LOW_LOAD_IN = 6'h0;
		ENABLE_PIN = 1'h0;
		wt(5);
		ENABLE_PIN = 1'h1;
		wt(6);
		chk({LATCHED_OFF, DRIVE_ENABLE, STATUS_WORD, BRIDGE_FAULT_CODE}, {6'h0, e & ~b, 28'h0});
		cfg(3'h4);
		LOW_LOAD_IN = b;
		wt(5);
		chk({DRIVE_ENABLE, STATUS_WORD, BRIDGE_FAULT_CODE}, {e, 16'h2000, code(b, 2'h2)});
		cfg(3'h5);
		chk({LATCHED_OFF, DRIVE_ENABLE}, {b, e & ~b});
		LOW_LOAD_IN = 6'h0;
		wt(4);
	end
	// clock enable low: a clear frame must leave the latched bits and status word frozen
	CE = 1'h0;
	cfg(3'h4);
	chk({LATCHED_OFF, STATUS_WORD}, {b, 16'h2000});
	CE = 1'h1;
	wt(2);
	summarize();
end
endmodule // hbf_fault_manager_tb
bind hbf_fault_manager hbf_checker #(.NB(NB)) chk_i (.*);
`default_nettype wire
